// file: rtl/hcp_pkg.sv
/*
 * hcp_pkg: constants, types and register layout of the high-speed clock
 * pin mode control block.
 * Assumes: included ahead of every hcp design file; nothing is imported.
 */
package hcp_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W  = 8;

  // byte addresses
  localparam logic [19:0] PIN_MODE_ADDR = 20'hf_ffa0; // clock_pin_mode_control
  localparam logic [19:0] LOCK_STS_ADDR = 20'hf_ffa4; // write-once status

  // clock_pin_mode_control field positions and reset value
  localparam int unsigned     EXT_CLK_BIT   = 7;
  localparam int unsigned     OSC_SEL_BIT   = 6;
  localparam int unsigned     FREQ_RNG_BIT  = 0;
  localparam logic [7:0]      PIN_MODE_RST  = 8'h00;
  localparam logic [7:0]      PIN_MODE_MASK = 8'hc1; // bits 1..3 and 5 (and 4) read 0

  // only byte lane 0 makes an 8-bit access to the register
  localparam logic [3:0] BYTE0_STRB = 4'h1;

  // lock status field
  localparam int unsigned LOCK_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // write-once state
  typedef enum logic [1:0] {
    CFG_OPEN   = 2'b01,
    CFG_LOCKED = 2'b10
  } hcp_lock_e;

  // decoded pin mode, one flag per pin function
  typedef struct packed {
    logic x1_osc_en;    // resonator across both pins
    logic x1_port_en;   // first pin as input port
    logic x2_port_en;   // second pin as input port
    logic x2_extclk_en; // second pin as external clock input
    logic freq_hi;      // crystal range above 10 MHz up to 20 MHz
  } hcp_pin_mode_s;

  localparam hcp_pin_mode_s PIN_MODE_DEC_RST = '{
    x1_osc_en: 1'b0, x1_port_en: 1'b1, x2_port_en: 1'b1,
    x2_extclk_en: 1'b0, freq_hi: 1'b0};

endpackage : hcp_pkg

// file: rtl/hcp_pin_decode.sv
/*
 * hcp_pin_decode: turns the stored pin mode byte into registered pin
 * function enables for the oscillator pad pair.
 * Assumes: cfg changes at most once per reset; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module hcp_pin_decode (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             cfg,
  output hcp_pkg::hcp_pin_mode_s      pin_mode
);

  hcp_pkg::hcp_pin_mode_s pin_mode_ff;
  hcp_pkg::hcp_pin_mode_s nxt_pin_mode;
  logic                   ext_sel;
  logic                   osc_sel;

  assign ext_sel = cfg[hcp_pkg::EXT_CLK_BIT];
  assign osc_sel = cfg[hcp_pkg::OSC_SEL_BIT];

  // mode decode; ext select alone falls back to input ports
  always_comb begin
    nxt_pin_mode              = hcp_pkg::PIN_MODE_DEC_RST;
    nxt_pin_mode.x1_osc_en    = osc_sel & ~ext_sel;
    nxt_pin_mode.x1_port_en   = ~(osc_sel & ~ext_sel);
    nxt_pin_mode.x2_port_en   = ~osc_sel;
    nxt_pin_mode.x2_extclk_en = osc_sel & ext_sel;
    nxt_pin_mode.freq_hi      = cfg[hcp_pkg::FREQ_RNG_BIT];
  end

  // registered so pad enables never glitch on a decode change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_mode_ff <= hcp_pkg::PIN_MODE_DEC_RST;
    end else begin
      pin_mode_ff <= nxt_pin_mode;
    end
  end

  assign pin_mode = pin_mode_ff;

endmodule : hcp_pin_decode

// file: rtl/hcp_clock_pin_ctrl.sv
/*
 * hcp_clock_pin_ctrl: write-once clock pin mode register behind an
 * AXI4-Lite slave, driving the high-speed oscillator pad pair enables.
 * Assumes: a single AXI4-Lite master on clk; the oscillator start gate
 * and CPU clock switch sit elsewhere and follow software order.
 */
// The implementer's own choice: register access over AXI4-Lite.
// Operation
// - pin mode register resets to zero; ext clock bit7, osc bit6, range bit0.
// - decode both 0 port, osc only resonator, ext only port, both ext clock.
// - range bit 0 means 1 to 10 MHz crystal, 1 means up to 20 MHz.
// - only one 8-bit write accepted after reset; software writes intended value.
// - crystal path supports up to 20 MHz; software selects no higher.
`timescale 1ns/1ps
module hcp_clock_pin_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // AXI4-Lite write address
  input  wire logic [19:0]            s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [19:0]            s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // pad pair control
  output hcp_pkg::hcp_pin_mode_s      pin_mode,
  output logic                        cfg_locked
);

  // bus channel holding state
  logic [19:0]        aw_addr_ff;
  logic               aw_held_ff;
  logic [7:0]         w_byte_ff;
  logic [3:0]         w_strb_ff;
  logic               w_held_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [1:0]         rresp_ff;
  logic [31:0]        rdata_ff;
  logic [7:0]         pin_cfg_ff;
  hcp_pkg::hcp_lock_e lock_ff;
  logic               wr_go;
  logic               wr_hit_cfg;
  logic               wr_hit_sts;
  logic               wr_ok;
  logic               rd_go;
  logic [1:0]         nxt_bresp;
  logic [1:0]         nxt_rresp;
  logic [31:0]        nxt_rdata;

  // true when an address names one of our two words
  function automatic logic is_mapped(input logic [19:0] addr);
    is_mapped = (addr == hcp_pkg::PIN_MODE_ADDR) || (addr == hcp_pkg::LOCK_STS_ADDR);
  endfunction : is_mapped

  // address and data taken independently, stalled while a response waits
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign wr_go         = aw_held_ff & w_held_ff & ~bvalid_ff;

  // write address holding register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 20'h0_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  // write data holding register; only the low byte is ever stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_byte_ff <= s_axi_wdata[7:0];
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  // a write lands only while open and only as a lone byte-0 access
  assign wr_hit_cfg = aw_addr_ff == hcp_pkg::PIN_MODE_ADDR;
  assign wr_hit_sts = aw_addr_ff == hcp_pkg::LOCK_STS_ADDR;
  assign wr_ok      = wr_go & wr_hit_cfg & (lock_ff == hcp_pkg::CFG_OPEN)
                    & (w_strb_ff == hcp_pkg::BYTE0_STRB);

  // response code: refused pin mode writes answer SLVERR, status is read-only
  always_comb begin
    if (!is_mapped(aw_addr_ff)) begin
      nxt_bresp = hcp_pkg::RESP_DECERR;
    end else if (wr_hit_sts || !wr_ok) begin
      nxt_bresp = hcp_pkg::RESP_SLVERR;
    end else begin
      nxt_bresp = hcp_pkg::RESP_OKAY;
    end
  end

  // write response channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= hcp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= nxt_bresp;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // pin mode byte; reserved bits are never stored so they read back zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_cfg_ff <= hcp_pkg::PIN_MODE_RST;
    end else if (wr_ok) begin
      pin_cfg_ff <= w_byte_ff & hcp_pkg::PIN_MODE_MASK;
    end
  end

  // write-once lock: any accepted write, even 00H, closes the register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_ff <= hcp_pkg::CFG_OPEN;
    end else begin
      unique case (lock_ff)
        hcp_pkg::CFG_OPEN: begin
          if (wr_ok) begin
            lock_ff <= hcp_pkg::CFG_LOCKED;
          end
        end
        hcp_pkg::CFG_LOCKED: begin
          lock_ff <= hcp_pkg::CFG_LOCKED;
        end
        default: begin
          lock_ff <= hcp_pkg::CFG_LOCKED; // illegal code fails safe
        end
      endcase
    end
  end

  // read channel: one outstanding read, answered the cycle after arrival
  assign s_axi_arready = ~rvalid_ff;
  assign rd_go         = s_axi_arvalid & s_axi_arready;

  // read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = hcp_pkg::RESP_OKAY;
    if (s_axi_araddr == hcp_pkg::PIN_MODE_ADDR) begin
      nxt_rdata[7:0] = pin_cfg_ff;
    end else if (s_axi_araddr == hcp_pkg::LOCK_STS_ADDR) begin
      nxt_rdata[hcp_pkg::LOCK_BIT] = (lock_ff == hcp_pkg::CFG_LOCKED);
    end else begin
      nxt_rresp = hcp_pkg::RESP_DECERR;
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= hcp_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // bus outputs straight from their flops
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;
  assign cfg_locked   = (lock_ff == hcp_pkg::CFG_LOCKED);

  // pad enable decode, one cycle behind the stored byte
  hcp_pin_decode u_decode (
    .clk      (clk),
    .rst_n    (rst_n),
    .cfg      (pin_cfg_ff),
    .pin_mode (pin_mode)
  );

endmodule : hcp_clock_pin_ctrl

// file: tb/hcp_osc_model.sv
/* hcp_osc_model: resonator or external clock source on the pad pair.
   assumes: pin_mode from the block under test, no other control. */
`timescale 1ns/1ps
module hcp_osc_model #(parameter int HALF_LO_NS = 62, parameter int HALF_HI_NS = 31) (
  input  wire hcp_pkg::hcp_pin_mode_s pin_mode,
  output logic                        osc_clk
);
  // about 8 MHz in the low range, 16 MHz in the high one, never above 20 MHz
  initial osc_clk = 1'b0;
  // stands still low unless a clock mode owns the pads
  always begin
    #(pin_mode.freq_hi ? HALF_HI_NS : HALF_LO_NS);
    osc_clk = (pin_mode.x1_osc_en || pin_mode.x2_extclk_en) ? !osc_clk : 1'b0;
  end
endmodule : hcp_osc_model

// file: tb/hcp_ctrl_sva.sv
/* hcp_ctrl_sva: write-once and pad decode relations at the ports.
   assumes: bound to hcp_clock_pin_ctrl, one clock, sync reset. */
`timescale 1ns/1ps
module hcp_ctrl_sva (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [19:0]            s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic [19:0]            s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire hcp_pkg::hcp_pin_mode_s pin_mode,
  input wire logic                   cfg_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // both halves of a pin mode write taken in one edge
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == hcp_pkg::PIN_MODE_ADDR;
  property p_rst; $rose(rst_n) |-> !cfg_locked && pin_mode == hcp_pkg::PIN_MODE_DEC_RST; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold; cfg_locked |=> cfg_locked; endproperty
  a_hold: assert property (p_hold) else $error("lock dropped");
  // both halves held one edge after the take, response flop one edge later
  property p_first; wr_go && !cfg_locked && s_axi_wstrb == hcp_pkg::BYTE0_STRB
    |-> ##2 cfg_locked && s_axi_bvalid && s_axi_bresp == hcp_pkg::RESP_OKAY; endproperty
  a_first: assert property (p_first) else $error("first write not taken");
  property p_strb; wr_go && s_axi_wstrb != hcp_pkg::BYTE0_STRB
    |-> ##2 s_axi_bvalid && s_axi_bresp == hcp_pkg::RESP_SLVERR && !$rose(cfg_locked);
  endproperty
  a_strb: assert property (p_strb) else $error("wide write accepted");
  property p_again; wr_go && cfg_locked
    |-> ##2 s_axi_bvalid && s_axi_bresp == hcp_pkg::RESP_SLVERR;
  endproperty
  a_again: assert property (p_again) else $error("second write accepted");
  property p_pins; cfg_locked [*2] |=> $stable(pin_mode); endproperty
  a_pins: assert property (p_pins) else $error("pads moved after lock");
  property p_ext; pin_mode.x2_extclk_en |-> pin_mode.x1_port_en && !pin_mode.x2_port_en
    && !pin_mode.x1_osc_en; endproperty
  a_ext: assert property (p_ext) else $error("ext clock decode wrong");
  property p_osc; pin_mode.x1_osc_en |-> !pin_mode.x1_port_en && !pin_mode.x2_port_en; endproperty
  a_osc: assert property (p_osc) else $error("resonator decode wrong");
  property p_rd; s_axi_arvalid && s_axi_arready && s_axi_araddr == hcp_pkg::PIN_MODE_ADDR
    |=> s_axi_rvalid && s_axi_rdata[31:8] == '0 && s_axi_rdata[5:1] == '0; endproperty
  a_rd: assert property (p_rd) else $error("fixed zero bits read back set");
endmodule : hcp_ctrl_sva
bind hcp_clock_pin_ctrl hcp_ctrl_sva hcp_ctrl_sva_inst (
  .clk           (clk),
  .rst_n         (rst_n),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wstrb   (s_axi_wstrb),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .pin_mode      (pin_mode),
  .cfg_locked    (cfg_locked)
);

// file: tb/hcp_clock_pin_ctrl_tb_top.sv
/* hcp_clock_pin_ctrl_tb_top: self-checking bench with a write-once model.
   assumes: design, package, checker and source model compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t: got %h exp %h", $time, g, e); end end
module hcp_clock_pin_ctrl_tb_top;
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cfg_locked, osc_clk;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] lf;
  logic [7:0]  v;
  hcp_pkg::hcp_pin_mode_s pin_mode;
  int          errors, cmp_count, osc_n, mdl_cfg, mdl_lock;
  hcp_clock_pin_ctrl hcp_clock_pin_ctrl_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (s_axi_awprot),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (s_axi_arprot),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pin_mode      (pin_mode),
    .cfg_locked    (cfg_locked)
  );
  hcp_osc_model hcp_osc_model_inst (.pin_mode(pin_mode), .osc_clk(osc_clk));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // source activity seen on the pads
  always @(posedge osc_clk) osc_n++;
  function automatic logic [15:0] nxt_lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt_lf
  // pad enables expected for a stored byte
  function automatic logic [4:0] dec(input logic [7:0] c);
    logic o, e;
    o = c[6] && !c[7];
    e = c[6] && c[7];
    return {o, !o, !o && !e, e, c[0]};
  endfunction : dec
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mdl_cfg = 0;
    mdl_lock = 0;
  endtask : rst
  // one write, address and data offered together, answer checked against the model
  task automatic wchk(input logic [19:0] a, input logic [31:0] wd, input logic [3:0] s);
    logic [1:0] e;
    e = (a != hcp_pkg::LOCK_STS_ADDR) ? hcp_pkg::RESP_DECERR : hcp_pkg::RESP_SLVERR;
    if (a == hcp_pkg::PIN_MODE_ADDR)
      e = (mdl_lock != 0 || s != hcp_pkg::BYTE0_STRB) ? hcp_pkg::RESP_SLVERR : hcp_pkg::RESP_OKAY;
    if (e == hcp_pkg::RESP_OKAY) begin
      mdl_cfg = int'(wd[7:0] & hcp_pkg::PIN_MODE_MASK);
      mdl_lock = 1;
    end
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    `CHK(s_axi_bresp, e)
    s_axi_bready <= 1'b0;
  endtask : wchk
  task automatic rchk(input logic [19:0] a);
    logic ok;
    ok = (a == hcp_pkg::PIN_MODE_ADDR || a == hcp_pkg::LOCK_STS_ADDR);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    `CHK(s_axi_rdata, 32'(a == hcp_pkg::PIN_MODE_ADDR ? mdl_cfg : ok ? mdl_lock : 0))
    `CHK(s_axi_rresp, ok ? hcp_pkg::RESP_OKAY : hcp_pkg::RESP_DECERR)
    s_axi_rready <= 1'b0;
  endtask : rchk
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("BAD %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    {errors, cmp_count, osc_n} = '0;
    lf = 16'h7834;
    rst();
    `CHK(pin_mode, hcp_pkg::hcp_pin_mode_s'(dec(8'h00)))
    `CHK(cfg_locked, 1'b0)
    rchk(hcp_pkg::PIN_MODE_ADDR);
    rchk(20'hf_ffa8);
    wchk(hcp_pkg::PIN_MODE_ADDR, 32'h0000_00c1, 4'h3);
    wchk(hcp_pkg::LOCK_STS_ADDR, 32'h0000_0001, hcp_pkg::BYTE0_STRB);
    wchk(20'h0_0010, 32'h0000_0041, hcp_pkg::BYTE0_STRB);
    // every mode and range, each after its own reset except the first, which follows the opening one
    for (int m = 0; m < 8; m++) begin
      if (m > 0) rst();
      lf = nxt_lf(lf);
      v = {m[2:1], 5'h00, m[0]}; // fixed zero bits kept clear
      wchk(hcp_pkg::PIN_MODE_ADDR, {lf, 8'h00, v}, hcp_pkg::BYTE0_STRB);
      wchk(hcp_pkg::PIN_MODE_ADDR, {lf, 8'h00, ~v}, hcp_pkg::BYTE0_STRB);
      rchk(hcp_pkg::PIN_MODE_ADDR);
      rchk(hcp_pkg::LOCK_STS_ADDR);
      osc_n = 0;
      repeat (4) @(posedge clk);
      `CHK(pin_mode, hcp_pkg::hcp_pin_mode_s'(dec(v)))
      `CHK(osc_n > 0, v[6])
      `CHK(osc_n > 4, v[6] & v[0])
      `CHK(cfg_locked, mdl_lock[0])
    end
    complete_run();
  end
endmodule : hcp_clock_pin_ctrl_tb_top
